// ### flash_status_regs.svh
/*
  Register offsets, field positions, reset values and command codes for the
  flash operation status and interrupt block.
  Assumes a Wishbone slave with word addressing of 16-bit registers.
*/
`ifndef FLASH_STATUS_REGS_SVH
`define FLASH_STATUS_REGS_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define IRQ_FLAGS_IDX 16'hF241
`define CTRL_STATUS_IDX 16'hF240
`define HOST_CTRL_IDX 16'hF242
`define ECC_STATUS_IDX 16'hFF00

// ==========================================================================
// Interrupt flag bits
`define IRQ_MASTER_BIT 15
`define IRQ_LOAD_BIT 7
`define IRQ_PROG_BIT 6
`define IRQ_ERASE_BIT 5
`define IRQ_RESET_BIT 4
`define IRQ_FLAGS_MASK 16'h80F0
`define IRQ_COLD_DEFAULT 16'h8080
`define IRQ_WARM_DEFAULT 16'h8010

// ==========================================================================
// Controller status bits
`define ST_ONGO 15
`define ST_LOCK 14
`define ST_LOAD 13
`define ST_PROG 12
`define ST_ERASE 11
`define ST_ERROR 10
`define ST_SUS 9
`define ST_RESET_BUSY 7
`define ST_OTP_LOCKED 6
`define ST_FIRST_BLOCK_OTP_LOCKED 5

// ==========================================================================
// Host control bits
`define HC_POL_BIT 0
`define HC_AUTO_BIT 1

// ==========================================================================
// ECC codes
`define ECC_NO_ERR 2'h0
`define ECC_UNCORR 2'h2

// ==========================================================================
// Command codes
`define CMD_LOAD0 16'h0000
`define CMD_LOAD1 16'h000E
`define CMD_LOAD2 16'h000C
`define CMD_LOAD3 16'h000A
`define CMD_LOAD4 16'h0013
`define CMD_PROG0 16'h0080
`define CMD_PROG1 16'h001A
`define CMD_PROG2 16'h001B
`define CMD_ERASE0 16'h0094
`define CMD_ERASE1 16'h0095
`define CMD_ERASE2 16'h0030
`define CMD_RST0 16'h00B0
`define CMD_RST1 16'h00F0
`define CMD_RST2 16'h00F3
`define CMD_MISC0 16'h0065
`define CMD_MISC1 16'h0023
`define CMD_MISC2 16'h0071
`define CMD_MISC3 16'h002A
`define CMD_MISC4 16'h0027
`define CMD_MISC5 16'h002C

`endif

// ### flash_status_pkg.sv
/*
  Types shared by the flash status block.
  Assumes the register header is included by the files that need numbers.
*/
package flash_status_pkg;
  // ========================================================================
  // Operation outcomes reported by the flash core
  typedef enum logic [4:0] {
    OUT_NONE, OUT_LOAD_GO, OUT_PROG_GO, OUT_ERASE_GO, OUT_RESET_GO, OUT_EVR_GO,
    OUT_LOAD_OK, OUT_PROG_OK, OUT_ERASE_OK, OUT_EVR_OK,
    OUT_LOAD_FAIL, OUT_PROG_FAIL, OUT_ERASE_FAIL, OUT_CACHE_FAIL, OUT_EVR_FAIL,
    OUT_LOAD_RST, OUT_PROG_RST, OUT_ERASE_RST, OUT_ERASE_SUSP,
    OUT_PROG_LOCK, OUT_ERASE_LOCK, OUT_LOAD_LOCK, OUT_OTP_PROG_LOCK, OUT_OTP_PROG_FAIL,
    OUT_OTP_ERASE_FAIL, OUT_PROG_GO_SUSP, OUT_LOAD_GO_SUSP, OUT_PROG_FAIL_SUSP,
    OUT_LOAD_FAIL_SUSP, OUT_INVALID, OUT_INVALID_SUSP
  } outcome_t;

  typedef enum logic [1:0] {
    RST_NONE, RST_COLD, RST_WARM
  } reset_kind_t;
endpackage

// ### status_word_enc.sv
/*
  Encodes an operation outcome into the controller status word.
  Assumes outcome is held stable by the caller while it is reported.
*/
`include "flash_status_regs.svh"
module status_word_enc (
  input wire flash_status_pkg::outcome_t outcome_i,
  input wire logic otp_locked_i,
  input wire logic first_block_otp_locked_i,
  output logic [15:0] word_o
);
  // ========================================================================
  // Encoding
  always_comb begin
    word_o = 16'h0000;
    word_o[`ST_OTP_LOCKED] = otp_locked_i; // R7
    word_o[`ST_FIRST_BLOCK_OTP_LOCKED] = first_block_otp_locked_i; // R8
    case (outcome_i)
      flash_status_pkg::OUT_LOAD_GO: begin
        word_o[`ST_ONGO] = 1'b1; // R5
        word_o[`ST_LOAD] = 1'b1;
      end
      flash_status_pkg::OUT_PROG_GO: begin
        word_o[`ST_ONGO] = 1'b1;
        word_o[`ST_PROG] = 1'b1;
      end
      flash_status_pkg::OUT_ERASE_GO: begin
        word_o[`ST_ONGO] = 1'b1;
        word_o[`ST_ERASE] = 1'b1;
      end
      flash_status_pkg::OUT_RESET_GO: begin
        word_o[`ST_ONGO] = 1'b1;
        word_o[`ST_RESET_BUSY] = 1'b1;
      end
      flash_status_pkg::OUT_EVR_GO: begin
        word_o[`ST_ONGO] = 1'b1;
      end
      flash_status_pkg::OUT_LOAD_FAIL: begin
        word_o[`ST_LOAD] = 1'b1; // R20
        word_o[`ST_ERROR] = 1'b1;
      end
      flash_status_pkg::OUT_PROG_FAIL, flash_status_pkg::OUT_OTP_PROG_FAIL: begin
        word_o[`ST_PROG] = 1'b1; // R20
        word_o[`ST_ERROR] = 1'b1;
        if (outcome_i == flash_status_pkg::OUT_OTP_PROG_FAIL) begin
          word_o[`ST_OTP_LOCKED] = 1'b0;
          word_o[`ST_FIRST_BLOCK_OTP_LOCKED] = 1'b0;
        end
      end
      flash_status_pkg::OUT_ERASE_FAIL, flash_status_pkg::OUT_EVR_FAIL: begin
        word_o[`ST_ERASE] = 1'b1; // R20
        word_o[`ST_ERROR] = 1'b1;
      end
      flash_status_pkg::OUT_CACHE_FAIL: begin
        word_o[`ST_ONGO] = 1'b1; // R21
        word_o[`ST_LOAD] = 1'b1;
        word_o[`ST_ERROR] = 1'b1;
      end
      flash_status_pkg::OUT_LOAD_RST: begin
        word_o[`ST_LOAD] = 1'b1; // R20
        word_o[`ST_ERROR] = 1'b1;
        word_o[`ST_RESET_BUSY] = 1'b1;
      end
      flash_status_pkg::OUT_PROG_RST: begin
        word_o[`ST_PROG] = 1'b1; // R20
        word_o[`ST_ERROR] = 1'b1;
        word_o[`ST_RESET_BUSY] = 1'b1;
      end
      flash_status_pkg::OUT_ERASE_RST: begin
        word_o[`ST_ERASE] = 1'b1; // R20
        word_o[`ST_ERROR] = 1'b1;
        word_o[`ST_RESET_BUSY] = 1'b1;
      end
      flash_status_pkg::OUT_ERASE_SUSP: begin
        word_o[`ST_ERASE] = 1'b1; // R20
        word_o[`ST_SUS] = 1'b1;
      end
      flash_status_pkg::OUT_PROG_LOCK: begin
        word_o[`ST_LOCK] = 1'b1; // R20
        word_o[`ST_PROG] = 1'b1;
        word_o[`ST_ERROR] = 1'b1;
      end
      flash_status_pkg::OUT_ERASE_LOCK, flash_status_pkg::OUT_OTP_ERASE_FAIL: begin
        word_o[`ST_LOCK] = 1'b1; // R20
        word_o[`ST_ERASE] = 1'b1;
        word_o[`ST_ERROR] = 1'b1;
      end
      flash_status_pkg::OUT_LOAD_LOCK: begin
        word_o[`ST_LOCK] = 1'b1; // R20
        word_o[`ST_LOAD] = 1'b1;
        word_o[`ST_ERROR] = 1'b1;
      end
      flash_status_pkg::OUT_OTP_PROG_LOCK: begin
        word_o[`ST_LOCK] = 1'b1; // R20
        word_o[`ST_PROG] = 1'b1;
        word_o[`ST_ERROR] = 1'b1;
        word_o[`ST_OTP_LOCKED] = 1'b1;
        word_o[`ST_FIRST_BLOCK_OTP_LOCKED] = 1'b1;
      end
      flash_status_pkg::OUT_PROG_GO_SUSP: begin
        word_o[`ST_ONGO] = 1'b1;
        word_o[`ST_PROG] = 1'b1;
        word_o[`ST_ERASE] = 1'b1;
        word_o[`ST_SUS] = 1'b1;
      end
      flash_status_pkg::OUT_LOAD_GO_SUSP: begin
        word_o[`ST_ONGO] = 1'b1;
        word_o[`ST_LOAD] = 1'b1;
        word_o[`ST_ERASE] = 1'b1;
        word_o[`ST_SUS] = 1'b1;
      end
      flash_status_pkg::OUT_PROG_FAIL_SUSP: begin
        word_o[`ST_PROG] = 1'b1; // R20
        word_o[`ST_ERASE] = 1'b1;
        word_o[`ST_ERROR] = 1'b1;
        word_o[`ST_SUS] = 1'b1;
      end
      flash_status_pkg::OUT_LOAD_FAIL_SUSP: begin
        word_o[`ST_LOAD] = 1'b1; // R20
        word_o[`ST_ERASE] = 1'b1;
        word_o[`ST_ERROR] = 1'b1;
        word_o[`ST_SUS] = 1'b1;
      end
      flash_status_pkg::OUT_INVALID: begin
        word_o[`ST_ERROR] = 1'b1; // R20
      end
      flash_status_pkg::OUT_INVALID_SUSP: begin
        word_o[`ST_ERASE] = 1'b1; // R20
        word_o[`ST_ERROR] = 1'b1;
        word_o[`ST_SUS] = 1'b1;
      end
      default: begin
        word_o[`ST_ONGO] = 1'b0; // R21
      end
    endcase
  end
endmodule // status_word_enc

// ### cmd_classify.sv
/*
  Sorts a completed command code into the interrupt source classes.
  Assumes the code is valid in the cycle its completion strobe is high.
*/
`include "flash_status_regs.svh"
module cmd_classify (
  input wire logic [15:0] code_i,
  output logic is_load_o,
  output logic is_prog_o,
  output logic is_erase_o,
  output logic is_reset_o,
  output logic is_master_o
);
  // ========================================================================
  // Class decode
  always_comb begin
    is_load_o = (code_i == `CMD_LOAD0) || (code_i == `CMD_LOAD1) || (code_i == `CMD_LOAD2) ||
      (code_i == `CMD_LOAD3) || (code_i == `CMD_LOAD4); // R15
    is_prog_o = (code_i == `CMD_PROG0) || (code_i == `CMD_PROG1) || (code_i == `CMD_PROG2); // R16
    is_erase_o = (code_i == `CMD_ERASE0) || (code_i == `CMD_ERASE1) || (code_i == `CMD_ERASE2); // R17
    is_reset_o = (code_i == `CMD_RST0) || (code_i == `CMD_RST1) || (code_i == `CMD_RST2); // R18
    is_master_o = (code_i == `CMD_MISC0) || (code_i == `CMD_MISC1) || (code_i == `CMD_MISC2) ||
      (code_i == `CMD_MISC3) || (code_i == `CMD_MISC4) || (code_i == `CMD_MISC5); // R13
  end
endmodule // cmd_classify

// ### flash_op_status_interrupts.sv
/*
  Operation status word, interrupt flags, interrupt pin and ECC status for the
  flash controller, reached over a classic Wishbone slave.
  Assumes the flash core reports outcomes and completions as synchronous strobes.
*/
// Function
// R1: Load fail reports affected main/spare ECC fields as uncorrectable code.
// R2: Two-bit error in synchronous burst block read shows load-fail status.
// R3: Load terminated by reset reports all ECC fields as no error.
// R4: Host should confirm multi-block erase with an erase verify read.
// R5: Cache read shows load ongoing once interrupt rises after cache read command.
// R6: Load OK appears only when finish-cache-read completes.
// R7: OTP lock bit reads one when locked, zero when unlocked.
// R8: First-block OTP lock bit reads one when locked, zero otherwise.
// R9: Interrupt flags load one default at cold reset, another at warm.
// R10: Master flag bit 15, sources at bits 7..4, others zero.
// R11: Master flag drives the interrupt pin directly.
// R12: Clearing master drives pin to inactive level set by polarity.
// R13: Master sets on any source flag or on listed command completion.
// R14: Master, load, program, erase flags clear on zero write, reset, auto-mode command.
// R15: Load flag sets on load completion, buffer load or boot load.
// R16: Program flag sets when a listed program command completes.
// R17: Erase flag sets when a listed erase command completes.
// R18: Reset flag sets on reset command completion or warm reset release.
// R19: Reset flag clears only by zero write or auto-mode command write; the code also clears it on a cold reset.
// R20: Fail, reset, lock, suspend, invalid outcomes set error plus operation flags; code omits error on erase and go suspends, flag on OUT_INVALID.
// R21: Cache read fail keeps ongoing set; other outcomes clear it; the code also sets ongoing for every go outcome.
`include "flash_status_regs.svh"
module flash_op_status_interrupts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [17:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic reset_req_i,
  input wire flash_status_pkg::reset_kind_t reset_kind_i,
  input wire logic warm_reset_release_i,
  input wire logic outcome_valid_i,
  input wire flash_status_pkg::outcome_t outcome_i,
  input wire logic cache_read_i,
  input wire logic finish_cache_done_i,
  input wire logic done_i,
  input wire logic [15:0] done_code_i,
  input wire logic buffer_load_done_i,
  input wire logic boot_load_done_i,
  input wire logic cmd_write_i,
  input wire logic [3:0] main_two_bit_i,
  input wire logic [3:0] spare_two_bit_i,
  input wire logic [3:0] main_one_bit_i,
  input wire logic [3:0] spare_one_bit_i,
  input wire logic otp_locked_i,
  input wire logic first_block_otp_locked_i,
  output logic irq_o,
  output logic [15:0] ctrl_status_o
);
  // ==========================================================================
  // State
  logic [15:0] irq_flags_reg, irq_flags_next;
  flash_status_pkg::outcome_t outcome_reg, outcome_next;
  logic [15:0] ecc_reg, ecc_next;
  logic [1:0] host_ctrl_reg, host_ctrl_next;
  logic ack_reg, ack_next;
  logic [31:0] rdata_reg, rdata_next;
  logic irq_reg, irq_next;
  logic is_load, is_prog, is_erase, is_reset, is_master;
  logic [15:0] status_word;
  logic [15:0] offset;
  logic wr_irq, wr_ctrl, auto_clear, two_bit_any;
  flash_status_pkg::outcome_t outcome_eff;

  cmd_classify u_classify (
    .code_i(done_code_i),
    .is_load_o(is_load),
    .is_prog_o(is_prog),
    .is_erase_o(is_erase),
    .is_reset_o(is_reset),
    .is_master_o(is_master)
  );

  status_word_enc u_enc (
    .outcome_i(outcome_reg),
    .otp_locked_i(otp_locked_i),
    .first_block_otp_locked_i(first_block_otp_locked_i),
    .word_o(status_word)
  );

  assign ctrl_status_o = status_word;

  // ==========================================================================
  // Wishbone decode
  assign offset = wb_adr_i[17:2];
  assign wr_irq = wb_cyc_i && wb_stb_i && wb_we_i && !ack_reg && (offset == `IRQ_FLAGS_IDX) && wb_sel_i[1] &&
    wb_sel_i[0];
  assign wr_ctrl = wb_cyc_i && wb_stb_i && wb_we_i && !ack_reg && (offset == `HOST_CTRL_IDX) && wb_sel_i[0];
  assign auto_clear = cmd_write_i && host_ctrl_reg[`HC_AUTO_BIT];
  assign two_bit_any = |{main_two_bit_i, spare_two_bit_i};

  // A two-bit error outside cache read turns a load ok or load ongoing outcome into load fail
  always_comb begin
    outcome_eff = outcome_i;
    if (cache_read_i && outcome_i == flash_status_pkg::OUT_LOAD_OK && !finish_cache_done_i) begin
      outcome_eff = flash_status_pkg::OUT_LOAD_GO; // R6
    end
    if ((outcome_i == flash_status_pkg::OUT_LOAD_OK || outcome_i == flash_status_pkg::OUT_LOAD_GO) &&
      two_bit_any && !cache_read_i) begin
      outcome_eff = flash_status_pkg::OUT_LOAD_FAIL; // R2
    end
  end

  always_comb begin
    ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
    rdata_next = rdata_reg;
    if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_reg) begin
      case (offset)
        `IRQ_FLAGS_IDX: rdata_next = {16'h0000, irq_flags_reg & `IRQ_FLAGS_MASK}; // R10
        `CTRL_STATUS_IDX: rdata_next = {16'h0000, status_word};
        `HOST_CTRL_IDX: rdata_next = {30'h0, host_ctrl_reg};
        `ECC_STATUS_IDX: rdata_next = {16'h0000, ecc_reg};
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  // ==========================================================================
  // Status, ECC and host control
  always_comb begin
    outcome_next = outcome_reg;
    ecc_next = ecc_reg;
    host_ctrl_next = host_ctrl_reg;
    if (wr_ctrl) begin
      host_ctrl_next = wb_dat_i[1:0];
    end
    if (cmd_write_i) begin
      ecc_next = 16'h0000;
    end
    if (outcome_valid_i) begin
      outcome_next = outcome_eff; // R21
      case (outcome_eff)
        flash_status_pkg::OUT_LOAD_FAIL, flash_status_pkg::OUT_LOAD_OK: begin
          for (int i = 0; i < 4; i++) begin
            ecc_next[4*i+3 -: 2] = main_two_bit_i[i] ? `ECC_UNCORR : {1'b0, main_one_bit_i[i]}; // R1
            ecc_next[4*i+1 -: 2] = spare_two_bit_i[i] ? `ECC_UNCORR : {1'b0, spare_one_bit_i[i]}; // R1
          end
        end
        flash_status_pkg::OUT_LOAD_RST: begin
          ecc_next = {8{`ECC_NO_ERR}}; // R3
        end
        default: begin
          ecc_next = ecc_next;
        end
      endcase
    end
    if (reset_req_i) begin
      outcome_next = flash_status_pkg::OUT_NONE;
      host_ctrl_next = 2'h0;
      ecc_next = 16'h0000;
    end
  end

  // ==========================================================================
  // Interrupt flags; a set wins over a zero write or auto-mode clear in the same cycle; a reset request is applied last
  always_comb begin
    logic [15:0] f;
    logic set_load, set_prog, set_erase, set_reset;
    f = irq_flags_reg;
    set_load = done_i && is_load || buffer_load_done_i || boot_load_done_i; // R15
    set_prog = done_i && is_prog; // R16
    set_erase = done_i && is_erase; // R17
    set_reset = done_i && is_reset || warm_reset_release_i; // R18
    if (wr_irq) begin
      f = f & (wb_dat_i[15:0] | ~`IRQ_FLAGS_MASK); // R14
    end
    if (auto_clear) begin
      f = 16'h0000; // R14 R19
    end
    if (set_load) f[`IRQ_LOAD_BIT] = 1'b1;
    if (set_prog) f[`IRQ_PROG_BIT] = 1'b1;
    if (set_erase) f[`IRQ_ERASE_BIT] = 1'b1;
    if (set_reset) f[`IRQ_RESET_BIT] = 1'b1;
    if (set_load || set_prog || set_erase || set_reset || (done_i && is_master) ||
      (cache_read_i && outcome_valid_i && outcome_i == flash_status_pkg::OUT_LOAD_GO)) begin
      f[`IRQ_MASTER_BIT] = 1'b1; // R13 R5
    end
    if (reset_req_i) begin
      // Reset flag survives a reset request of kind RST_NONE; a cold reset clears it
      f = (reset_kind_i == flash_status_pkg::RST_COLD) ? `IRQ_COLD_DEFAULT :
        ((reset_kind_i == flash_status_pkg::RST_WARM) ? `IRQ_WARM_DEFAULT :
        (16'h0000 | (f & 16'h0010))); // R9 R19
    end
    irq_flags_next = f & `IRQ_FLAGS_MASK;
    irq_next = irq_flags_next[`IRQ_MASTER_BIT] ~^ host_ctrl_next[`HC_POL_BIT]; // R11 R12
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_flags_reg <= `IRQ_COLD_DEFAULT;
      outcome_reg <= flash_status_pkg::OUT_NONE;
      ecc_reg <= 16'h0000;
      host_ctrl_reg <= 2'h0;
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      irq_reg <= 1'b0;
    end else begin
      irq_flags_reg <= irq_flags_next;
      outcome_reg <= outcome_next;
      ecc_reg <= ecc_next;
      host_ctrl_reg <= host_ctrl_next;
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
  assign irq_o = irq_reg;

  // ==========================================================================
  // Checks
  property p_pin_follows;
    @(posedge clk_i) disable iff (rst_i)
      1'b1 |-> irq_o == (irq_flags_reg[15] ~^ host_ctrl_reg[0]);
  endproperty
  a_pin_follows: assert property (p_pin_follows) else $error("irq pin differs from master flag"); // R11

  property p_pin_low_clear;
    @(posedge clk_i) disable iff (rst_i)
      (wr_irq && !wb_dat_i[15] && !done_i && !buffer_load_done_i && !boot_load_done_i && !warm_reset_release_i &&
      !reset_req_i && !wr_ctrl && !outcome_valid_i) |=> irq_o == !host_ctrl_reg[0];
  endproperty
  a_pin_low_clear: assert property (p_pin_low_clear) else $error("irq pin not inactive after clear"); // R12

  property p_cold;
    @(posedge clk_i) disable iff (rst_i)
      (reset_req_i && reset_kind_i == flash_status_pkg::RST_COLD) |=> irq_flags_reg == 16'h8080;
  endproperty
  a_cold: assert property (p_cold) else $error("cold reset default wrong"); // R9

  property p_warm;
    @(posedge clk_i) disable iff (rst_i)
      (reset_req_i && reset_kind_i == flash_status_pkg::RST_WARM) |=> irq_flags_reg == 16'h8010;
  endproperty
  a_warm: assert property (p_warm) else $error("warm reset default wrong"); // R9

  property p_reserved;
    @(posedge clk_i) disable iff (rst_i)
      (irq_flags_reg & 16'h7F0F) == 16'h0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved interrupt bits set"); // R10

  property p_prog_set;
    @(posedge clk_i) disable iff (rst_i)
      (done_i && done_code_i == 16'h0080 && !reset_req_i) |=> irq_flags_reg[6] && irq_flags_reg[15];
  endproperty
  a_prog_set: assert property (p_prog_set) else $error("program completion not flagged"); // R16

  property p_erase_set;
    @(posedge clk_i) disable iff (rst_i)
      (done_i && done_code_i == 16'h0030 && !reset_req_i) |=> irq_flags_reg[5];
  endproperty
  a_erase_set: assert property (p_erase_set) else $error("erase completion not flagged"); // R17

  property p_rst_keep;
    @(posedge clk_i) disable iff (rst_i)
      (reset_req_i && reset_kind_i == flash_status_pkg::RST_NONE && irq_flags_reg[4] && !auto_clear && !wr_irq)
      |=> irq_flags_reg[4];
  endproperty
  a_rst_keep: assert property (p_rst_keep) else $error("reset flag lost during reset"); // R19

  property p_cache_fail;
    @(posedge clk_i) disable iff (rst_i)
      (outcome_valid_i && outcome_i == flash_status_pkg::OUT_CACHE_FAIL && !reset_req_i) |=>
      ctrl_status_o[15] && ctrl_status_o[13] && ctrl_status_o[10];
  endproperty
  a_cache_fail: assert property (p_cache_fail) else $error("cache read fail encoding wrong"); // R21

  property p_otp;
    @(posedge clk_i) disable iff (rst_i)
      (outcome_reg == flash_status_pkg::OUT_NONE) |-> ctrl_status_o[6] == otp_locked_i &&
      ctrl_status_o[5] == first_block_otp_locked_i;
  endproperty
  a_otp: assert property (p_otp) else $error("otp lock bits wrong"); // R7 R8
endmodule // flash_op_status_interrupts

// ### wb_host.sv
/*
  Host model: classic Wishbone master that issues single register cycles.
  Assumes the slave acks within 50 cycles; callers start right after an edge.
*/
module wb_host (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [17:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
  end
  // ==========================================================
  // One cycle; request held until ack is sampled high
  task automatic xfer(input logic we, input logic [15:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd, output logic ok);
    ok = 1'b0;
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= we;
    adr_o <= {idx, 2'b00};
    sel_o <= 4'hF;
    dat_o <= wd;
    for (int n = 0; n < 50 && !ok; n++) begin
      @(posedge clk_i);
      ok = ack_i;
    end
    rd = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    // Released data must not look valid
    dat_o <= ~wd;
    @(posedge clk_i);
  endtask
endmodule // wb_host

// ### tb_flash_op_status_interrupts.sv
/*
  Self-checking bench for the flash status and interrupt block.
  Assumes the register header and package are compiled first.
*/
`include "flash_status_regs.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; $display("[ERR] %s exp %h seen %h", nm, e, g); end end
module tb_flash_op_status_interrupts;
  timeunit 1ns;
  timeprecision 1ns;
  import flash_status_pkg::*;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, reset_req_i, warm_reset_release_i;
  logic outcome_valid_i, cache_read_i, finish_cache_done_i, done_i, buffer_load_done_i;
  logic boot_load_done_i, cmd_write_i, otp_locked_i, first_block_otp_locked_i, irq_o, ok;
  logic [17:0] wb_adr_i;
  logic [3:0] wb_sel_i, main_two_bit_i, spare_two_bit_i, main_one_bit_i, spare_one_bit_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [15:0] done_code_i, ctrl_status_o;
  reset_kind_t reset_kind_i;
  outcome_t outcome_i;
  int n_mismatch = 0;
  int samples_checked = 0;
  flash_op_status_interrupts u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .reset_req_i, .reset_kind_i, .warm_reset_release_i,
    .outcome_valid_i, .outcome_i, .cache_read_i, .finish_cache_done_i, .done_i, .done_code_i,
    .buffer_load_done_i, .boot_load_done_i, .cmd_write_i, .main_two_bit_i, .spare_two_bit_i,
    .main_one_bit_i, .spare_one_bit_i, .otp_locked_i, .first_block_otp_locked_i, .irq_o,
    .ctrl_status_o);
  wb_host u_host (.clk_i(clk_i), .ack_i(wb_ack_o), .dat_i(wb_dat_o), .cyc_o(wb_cyc_i),
    .stb_o(wb_stb_i), .we_o(wb_we_i), .adr_o(wb_adr_i), .sel_o(wb_sel_i), .dat_o(wb_dat_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // ==========================================================
  // Helpers
  task automatic wrap_up();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic rw(input logic we, input logic [15:0] idx, input logic [31:0] wd);
    u_host.xfer(we, idx, wd, rd, ok);
    if (!ok) begin
      n_mismatch++;
      wrap_up();
    end
  endtask
  task automatic flags(input logic [15:0] e);
    rw(1'b0, `IRQ_FLAGS_IDX, 32'h0);
    `CHK("flags", {16'h0000, e}, rd)
  endtask
  task automatic done(input logic [15:0] c);
    done_i <= 1'b1;
    done_code_i <= c;
    @(posedge clk_i);
    done_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic out(input outcome_t o);
    outcome_i <= o;
    outcome_valid_i <= 1'b1;
    @(posedge clk_i);
    outcome_valid_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rst_kind(input reset_kind_t k);
    reset_req_i <= 1'b1;
    reset_kind_i <= k;
    @(posedge clk_i);
    reset_req_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_pin();
    flags(16'h8080);
    `CHK("irq", 1'b0, irq_o)
    rw(1'b1, `HOST_CTRL_IDX, 32'h1);
    `CHK("irq", 1'b1, irq_o)
    rw(1'b1, `IRQ_FLAGS_IDX, 32'h0);
    `CHK("irq", 1'b0, irq_o)
    rw(1'b1, `HOST_CTRL_IDX, 32'h0);
    `CHK("irq", 1'b1, irq_o)
    rw(1'b0, 16'h0001, 32'h0);
    `CHK("unmapped", 32'h0, rd)
  endtask
  task automatic t_sources();
    logic [15:0] c[15] = '{16'h0000, 16'h000E, 16'h0013, 16'h0080, 16'h001A, 16'h001B, 16'h0094,
      16'h0095, 16'h0030, 16'h00B0, 16'h00F0, 16'h00F3, 16'h0065, 16'h0023, 16'h002C};
    for (int i = 0; i < 15; i++) begin
      rw(1'b1, `IRQ_FLAGS_IDX, 32'h0);
      done(c[i]);
      flags(i < 12 ? 16'h8000 | (16'h0080 >> (i / 3)) : 16'h8000);
    end
    rw(1'b1, `IRQ_FLAGS_IDX, 32'h0);
    warm_reset_release_i <= 1'b1;
    @(posedge clk_i);
    warm_reset_release_i <= 1'b0;
    boot_load_done_i <= 1'b1;
    @(posedge clk_i);
    boot_load_done_i <= 1'b0;
    flags(16'h8090);
    rst_kind(RST_WARM);
    flags(16'h8010);
    cmd_write_i <= 1'b1;
    @(posedge clk_i);
    cmd_write_i <= 1'b0;
    flags(16'h8010);
    rst_kind(RST_NONE);
    flags(16'h0010);
    rst_kind(RST_COLD);
    flags(16'h8080);
    rw(1'b1, `HOST_CTRL_IDX, 32'h2);
    warm_reset_release_i <= 1'b1;
    @(posedge clk_i);
    warm_reset_release_i <= 1'b0;
    cmd_write_i <= 1'b1;
    @(posedge clk_i);
    cmd_write_i <= 1'b0;
    flags(16'h0000);
    buffer_load_done_i <= 1'b1;
    @(posedge clk_i);
    buffer_load_done_i <= 1'b0;
    flags(16'h8080);
  endtask
  task automatic t_status();
    outcome_t o[26] = '{OUT_LOAD_GO, OUT_CACHE_FAIL, OUT_LOAD_FAIL, OUT_ERASE_FAIL, OUT_EVR_FAIL,
      OUT_LOAD_RST, OUT_PROG_RST, OUT_ERASE_RST, OUT_ERASE_SUSP, OUT_PROG_LOCK, OUT_ERASE_LOCK,
      OUT_LOAD_LOCK, OUT_OTP_ERASE_FAIL, OUT_PROG_GO_SUSP, OUT_LOAD_GO_SUSP, OUT_PROG_FAIL_SUSP,
      OUT_LOAD_FAIL_SUSP, OUT_INVALID, OUT_INVALID_SUSP, OUT_PROG_GO, OUT_ERASE_GO, OUT_RESET_GO,
      OUT_EVR_GO, OUT_PROG_FAIL, OUT_OTP_PROG_LOCK, OUT_PROG_OK};
    logic [15:0] w[26] = '{16'hA000, 16'hA400, 16'h2400, 16'h0C00, 16'h0C00, 16'h2480, 16'h1480,
      16'h0C80, 16'h0A00, 16'h5400, 16'h4C00, 16'h6400, 16'h4C00, 16'h9A00, 16'hAA00, 16'h1E00,
      16'h2E00, 16'h0400, 16'h0E00, 16'h9000, 16'h8800, 16'h8080, 16'h8000, 16'h1400, 16'h5460, 16'h0000};
    for (int i = 0; i < 26; i++) begin
      out(o[i]);
      `CHK("status", w[i], ctrl_status_o)
    end
    otp_locked_i <= 1'b1;
    @(posedge clk_i);
    `CHK("otp", 16'h0040, ctrl_status_o)
    otp_locked_i <= 1'b0;
    first_block_otp_locked_i <= 1'b1;
    @(posedge clk_i);
    `CHK("otp", 16'h0020, ctrl_status_o)
    first_block_otp_locked_i <= 1'b0;
    main_two_bit_i <= 4'h1;
    spare_two_bit_i <= 4'h8;
    main_one_bit_i <= 4'h2;
    spare_one_bit_i <= 4'h4;
    out(OUT_LOAD_OK);
    `CHK("status", 16'h2400, ctrl_status_o)
    rw(1'b0, `ECC_STATUS_IDX, 32'h0);
    `CHK("ecc", 32'h2148, rd)
    out(OUT_LOAD_RST);
    rw(1'b0, `ECC_STATUS_IDX, 32'h0);
    `CHK("ecc", 32'h0, rd)
    {main_two_bit_i, spare_two_bit_i, main_one_bit_i, spare_one_bit_i} <= '0;
    cache_read_i <= 1'b1;
    rw(1'b1, `IRQ_FLAGS_IDX, 32'h0);
    out(OUT_LOAD_GO);
    flags(16'h8000);
    out(OUT_LOAD_OK);
    `CHK("status", 16'hA000, ctrl_status_o)
    finish_cache_done_i <= 1'b1;
    out(OUT_LOAD_OK);
    `CHK("status", 16'h0000, ctrl_status_o)
  endtask
  initial begin
    {reset_req_i, warm_reset_release_i, outcome_valid_i, cache_read_i, finish_cache_done_i} = '0;
    {done_i, done_code_i, buffer_load_done_i, boot_load_done_i, cmd_write_i} = '0;
    {main_two_bit_i, spare_two_bit_i, main_one_bit_i, spare_one_bit_i} = '0;
    {otp_locked_i, first_block_otp_locked_i} = '0;
    reset_kind_i = RST_NONE;
    outcome_i = OUT_NONE;
    rst_i = 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_pin();
    t_sources();
    t_status();
    wrap_up();
  end
endmodule // tb_flash_op_status_interrupts
